// ### design/speaker_driver_routing_control.sv
// speaker driver routing register behind the serial control port, with its output controls
// What this block does
// [RULE1] top bit picks single-ended (0) or differential (1) drivers; resets to 0
// [RULE2] differential mode without both drivers powered forces both drivers down
// [RULE3] driver one dac field: none, left, right, average; resets to 00
// [RULE4] sidetone bit routes sidetone to driver one or the pair; resets 0
// [RULE5] buzzer bit routes buzzer stage to driver one or the pair; resets 0
// [RULE6] keyclick bit routes keyclick to driver one or the pair; resets 0
// [RULE7] cell-phone bit routes cell input to driver one or the pair; resets 0
// [RULE8] driver two dac field, single-ended only: none, left, right, average; resets 00
// [RULE9] driver two sidetone bit, single-ended only; resets 0
// [RULE10] driver two buzzer bit, single-ended only; resets 0
// [RULE11] driver two keyclick bit, single-ended only; resets 0
// [RULE12] driver two cell-phone bit, single-ended only; resets 0
// [RULE13] driver one or pair mute bit, 1 mutes; resets to 1
// [RULE14] driver two mute bit, single-ended only, 1 mutes; resets to 1
// [RULE15] write-only low bit: 0 enables, 1 disables headphone short protection; enabled at reset
// [RULE16] software reaches this register at address 20h of page 2
// [RULE17] reads return zero in the protection bit, stored values elsewhere
`timescale 1ns/1ps
module speaker_driver_routing_control
  import spk_route_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             ce,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             mosi,
  input  wire logic             drv1_powered,
  input  wire logic             earpiece_powered,
  output logic                  miso,
  output logic                  miso_oe,
  output logic                  diff_output_select,
  output logic      [DAC_W-1:0] dac_route_drv1,
  output logic                  sidetone_route_drv1,
  output logic                  buzzer_route_drv1,
  output logic                  keyclick_route_drv1,
  output logic                  cellin_route_drv1,
  output logic      [DAC_W-1:0] dac_route_drv2,
  output logic                  sidetone_route_drv2,
  output logic                  buzzer_route_drv2,
  output logic                  keyclick_route_drv2,
  output logic                  cellin_route_drv2,
  output logic                  drv1_mute,
  output logic                  drv2_mute,
  output logic                  hp_short_prot_disable,
  output logic                  drv1_force_pd,
  output logic                  earpiece_force_pd
);

  logic [PIN_CNT-1:0] pin_q;
  logic               sclk_rise;
  logic               sclk_fall;
  logic [DATA_W-1:0]  shift_in;

  frame_state_t       state_r;
  frame_state_t       state_nxt;
  logic [CNT_W-1:0]   cnt_r;
  logic [CNT_W-1:0]   cnt_nxt;
  logic [DATA_W-1:0]  rx_r;
  logic [DATA_W-1:0]  rx_nxt;
  logic               rw_r;
  logic               rw_nxt;
  logic [PAGE_W-1:0]  page_r;
  logic [PAGE_W-1:0]  page_nxt;
  logic [ADDR_W-1:0]  addr_r;
  logic [ADDR_W-1:0]  addr_nxt;
  logic [DATA_W-1:0]  tx_r;
  logic [DATA_W-1:0]  tx_nxt;
  logic               miso_r;
  logic               miso_nxt;
  logic               miso_oe_r;
  logic               miso_oe_nxt;
  logic               wr_stb_r;
  logic               wr_stb_nxt;
  logic [DATA_W-1:0]  wdata_r;
  logic [DATA_W-1:0]  wdata_nxt;
  logic               sclk_d_r;
  logic               sclk_d_nxt;

  logic [DATA_W-1:0]  cfg_r;
  logic [DATA_W-1:0]  cfg_nxt;
  logic [DATA_W-1:0]  drive_r;
  logic [DATA_W-1:0]  drive_nxt;

  pd_if pd ();

  // serial clock is oversampled, so it must stay below a quarter of clk
  pin_sync #(
    .W         (PIN_CNT),
    .RESET_VAL (PIN_RESET)
  ) u_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .d     ({mosi, cs_n, sclk}),
    .q     (pin_q)
  );

  assign sclk_rise = pin_q[PIN_SCLK] & ~sclk_d_r;
  assign sclk_fall = ~pin_q[PIN_SCLK] & sclk_d_r;
  assign shift_in  = {rx_r[DATA_W-2:0], pin_q[PIN_MOSI]};

  // frame engine: data sampled on rising sclk, read data launched on falling sclk
  always_comb begin
    state_nxt   = state_r;
    cnt_nxt     = cnt_r;
    rx_nxt      = rx_r;
    rw_nxt      = rw_r;
    page_nxt    = page_r;
    addr_nxt    = addr_r;
    tx_nxt      = tx_r;
    miso_nxt    = miso_r;
    miso_oe_nxt = miso_oe_r;
    wr_stb_nxt  = 1'b0;
    wdata_nxt   = wdata_r;
    sclk_d_nxt  = pin_q[PIN_SCLK];
    case (state_r)
      ST_IDLE: begin
        miso_oe_nxt = 1'b0;
        if (!pin_q[PIN_CSN]) begin
          state_nxt = ST_CMD;
          cnt_nxt   = '0;
        end
      end
      ST_CMD: begin
        if (pin_q[PIN_CSN]) begin
          state_nxt = ST_IDLE;
        end else if (sclk_rise) begin
          rx_nxt  = shift_in;
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == CMD_BITS - 1'b1) begin
            state_nxt = ST_DATA;
            rw_nxt    = shift_in[CMD_RW_BIT];
            page_nxt  = shift_in[CMD_PAGE_LSB +: PAGE_W];
            addr_nxt  = shift_in[CMD_ADDR_LSB +: ADDR_W];
            if (shift_in[CMD_RW_BIT]) begin
              // unmapped addresses read as zero
              if (is_route_reg(shift_in[CMD_PAGE_LSB +: PAGE_W],
                               shift_in[CMD_ADDR_LSB +: ADDR_W])) begin // [RULE16]
                tx_nxt = cfg_r & READ_MASK; // [RULE17]
              end else begin
                tx_nxt = '0;
              end
              miso_nxt    = tx_nxt[DATA_W-1];
              miso_oe_nxt = 1'b1;
            end
          end
        end
      end
      ST_DATA: begin
        if (pin_q[PIN_CSN]) begin
          state_nxt   = ST_IDLE;
          miso_oe_nxt = 1'b0;
        end else if (sclk_rise && cnt_r != FRAME_BITS) begin
          rx_nxt  = shift_in;
          cnt_nxt = cnt_r + 1'b1;
          if (cnt_r == FRAME_BITS - 1'b1 && !rw_r) begin
            wr_stb_nxt = 1'b1;
            wdata_nxt  = shift_in;
          end
        end else if (sclk_fall && rw_r && cnt_r > CMD_BITS && cnt_r != FRAME_BITS) begin
          // first data bit was launched with the load, so shifting starts one edge later
          tx_nxt   = {tx_r[DATA_W-2:0], 1'b0};
          miso_nxt = tx_r[DATA_W-2];
        end
      end
      default: begin
        state_nxt   = ST_IDLE;
        miso_oe_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r   <= ST_IDLE;
      cnt_r     <= '0;
      rx_r      <= '0;
      rw_r      <= 1'b0;
      page_r    <= '0;
      addr_r    <= '0;
      tx_r      <= '0;
      miso_r    <= 1'b0;
      miso_oe_r <= 1'b0;
      wr_stb_r  <= 1'b0;
      wdata_r   <= '0;
      sclk_d_r  <= 1'b0;
    end else if (ce) begin
      state_r   <= state_nxt;
      cnt_r     <= cnt_nxt;
      rx_r      <= rx_nxt;
      rw_r      <= rw_nxt;
      page_r    <= page_nxt;
      addr_r    <= addr_nxt;
      tx_r      <= tx_nxt;
      miso_r    <= miso_nxt;
      miso_oe_r <= miso_oe_nxt;
      wr_stb_r  <= wr_stb_nxt;
      wdata_r   <= wdata_nxt;
      sclk_d_r  <= sclk_d_nxt;
    end
  end

  // register and effective driver controls
  always_comb begin
    cfg_nxt = cfg_r;
    if (wr_stb_r && is_route_reg(page_r, addr_r)) begin // [RULE16]
      cfg_nxt = wdata_r; // [RULE15]
    end
    drive_nxt = cfg_r;
    // driver two fields have no meaning across the differential pair: keep it silent
    if (cfg_r[DIFF_BIT]) begin // [RULE1]
      drive_nxt[DRV2_LSB +: GROUP_W] = '0; // [RULE8] [RULE9] [RULE10] [RULE11] [RULE12]
      drive_nxt[MUTE2_BIT]           = 1'b1; // [RULE14]
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r   <= CFG_RESET;
      drive_r <= CFG_RESET;
    end else if (ce) begin
      cfg_r   <= cfg_nxt;
      drive_r <= drive_nxt;
    end
  end

  assign pd.diff    = drive_r[DIFF_BIT];
  assign pd.drv1_up = drv1_powered;
  assign pd.ear_up  = earpiece_powered;

  diff_guard u_guard (
    .clk   (clk),
    .rst_n (rst_n),
    .ce    (ce),
    .pd    (pd)
  );

  assign miso                  = miso_r;
  assign miso_oe               = miso_oe_r;
  assign diff_output_select    = drive_r[DIFF_BIT]; // [RULE1]
  assign dac_route_drv1        = drive_r[DAC1_LSB +: DAC_W]; // [RULE3]
  assign sidetone_route_drv1   = drive_r[AST1_BIT]; // [RULE4]
  assign buzzer_route_drv1     = drive_r[BUZ1_BIT]; // [RULE5]
  assign keyclick_route_drv1   = drive_r[KCL1_BIT]; // [RULE6]
  assign cellin_route_drv1     = drive_r[CPI1_BIT]; // [RULE7]
  assign dac_route_drv2        = drive_r[DAC2_LSB +: DAC_W]; // [RULE8]
  assign sidetone_route_drv2   = drive_r[AST2_BIT]; // [RULE9]
  assign buzzer_route_drv2     = drive_r[BUZ2_BIT]; // [RULE10]
  assign keyclick_route_drv2   = drive_r[KCL2_BIT]; // [RULE11]
  assign cellin_route_drv2     = drive_r[CPI2_BIT]; // [RULE12]
  assign drv1_mute             = drive_r[MUTE1_BIT]; // [RULE13]
  assign drv2_mute             = drive_r[MUTE2_BIT]; // [RULE14]
  assign hp_short_prot_disable = drive_r[PROT_BIT]; // [RULE15]
  assign drv1_force_pd         = pd.drv1_pd; // [RULE2]
  assign earpiece_force_pd     = pd.ear_pd; // [RULE2]

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  a_write_take: assert property ( // [RULE15]
    ce && wr_stb_r && is_route_reg(page_r, addr_r) |=> cfg_r == $past(wdata_r))
    else $error("register did not take written word");

  a_cfg_hold: assert property ( // [RULE13]
    !wr_stb_r |=> $stable(cfg_r))
    else $error("register changed without a write");

  a_mode_out: assert property ( // [RULE1]
    ce |=> diff_output_select == $past(cfg_r[DIFF_BIT]))
    else $error("mode output does not follow register");

  a_drv1_route: assert property ( // [RULE3]
    ce |=> {dac_route_drv1, sidetone_route_drv1, buzzer_route_drv1, keyclick_route_drv1,
            cellin_route_drv1} == $past(cfg_r[DRV1_LSB +: GROUP_W])
           && drv1_mute == $past(cfg_r[MUTE1_BIT]))
    else $error("driver one controls do not follow register");

  a_drv2_single: assert property ( // [RULE9]
    ce && !cfg_r[DIFF_BIT] |=>
      {dac_route_drv2, sidetone_route_drv2, buzzer_route_drv2, keyclick_route_drv2,
       cellin_route_drv2} == $past(cfg_r[DRV2_LSB +: GROUP_W])
      && drv2_mute == $past(cfg_r[MUTE2_BIT]))
    else $error("driver two controls wrong in single-ended mode");

  a_drv2_diff: assert property ( // [RULE8]
    ce && cfg_r[DIFF_BIT] |=>
      dac_route_drv2 == '0 && !sidetone_route_drv2 && !buzzer_route_drv2
      && !keyclick_route_drv2 && !cellin_route_drv2 && drv2_mute)
    else $error("driver two not silenced in differential mode");

  a_force_pd: assert property ( // [RULE2]
    ce && diff_output_select && !(drv1_powered && earpiece_powered)
      |=> drv1_force_pd && earpiece_force_pd)
    else $error("drivers not forced down in bad differential setup");

  a_no_force: assert property ( // [RULE2]
    ce && !(diff_output_select && !(drv1_powered && earpiece_powered))
      |=> !drv1_force_pd && !earpiece_force_pd)
    else $error("drivers forced down without cause");

  a_read_lsb: assert property ( // [RULE17]
    $rose(miso_oe_r) |-> tx_r[PROT_BIT] == 1'b0 && miso_r == tx_r[DATA_W-1])
    else $error("read word exposes protection bit");

  a_frame_end: assert property (
    ce && pin_q[PIN_CSN] |=> state_r == ST_IDLE && !miso_oe_r)
    else $error("frame not closed after chip select rise");

  c_write_hit: cover property (ce && wr_stb_r && is_route_reg(page_r, addr_r));
  c_read_frame: cover property ($rose(miso_oe_r) ##[1:600] $fell(miso_oe_r));
  c_force_pd: cover property ($rose(drv1_force_pd));
  c_diff_mode: cover property ($rose(diff_output_select));

endmodule

// ### design/spk_route_pkg.sv
// shared constants, state type and register decode for the speaker driver routing block
package spk_route_pkg;

  localparam int DATA_W  = 16;
  localparam int CNT_W   = 6;
  localparam int PAGE_W  = 4;
  localparam int ADDR_W  = 6;
  localparam int DAC_W   = 2;
  localparam int GROUP_W = 6;
  localparam int PIN_CNT = 3;

  // serial frame: 16-bit command word, then 16-bit data word, msb first
  localparam logic [CNT_W-1:0] CMD_BITS   = 6'h10;
  localparam logic [CNT_W-1:0] FRAME_BITS = 6'h20;
  localparam int               CMD_RW_BIT   = 15;
  localparam int               CMD_PAGE_LSB = 11;
  localparam int               CMD_ADDR_LSB = 5;

  localparam logic [PAGE_W-1:0] ROUTE_PAGE = 4'h2;
  localparam logic [ADDR_W-1:0] ROUTE_ADDR = 6'h20;

  // both mute bits set, everything else clear
  localparam logic [DATA_W-1:0] CFG_RESET = 16'h0006;
  // protection control bit is write-only and reads as zero
  localparam logic [DATA_W-1:0] READ_MASK = 16'hfffe;

  localparam int DIFF_BIT  = 15;
  localparam int DAC1_LSB  = 13;
  localparam int DRV1_LSB  = 9;
  localparam int AST1_BIT  = 12;
  localparam int BUZ1_BIT  = 11;
  localparam int KCL1_BIT  = 10;
  localparam int CPI1_BIT  = 9;
  localparam int DAC2_LSB  = 7;
  localparam int DRV2_LSB  = 3;
  localparam int AST2_BIT  = 6;
  localparam int BUZ2_BIT  = 5;
  localparam int KCL2_BIT  = 4;
  localparam int CPI2_BIT  = 3;
  localparam int MUTE1_BIT = 2;
  localparam int MUTE2_BIT = 1;
  localparam int PROT_BIT  = 0;

  localparam int                PIN_SCLK  = 0;
  localparam int                PIN_CSN   = 1;
  localparam int                PIN_MOSI  = 2;
  localparam logic [PIN_CNT-1:0] PIN_RESET = 3'h2;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CMD  = 3'b010,
    ST_DATA = 3'b100
  } frame_state_t;

  function automatic logic is_route_reg(input logic [PAGE_W-1:0] page,
                                        input logic [ADDR_W-1:0] addr);
    return (page == ROUTE_PAGE) && (addr == ROUTE_ADDR);
  endfunction

endpackage

// ### design/pd_if.sv
// power-down guard signals between the register block and the guard
`timescale 1ns/1ps
interface pd_if;
  logic diff;
  logic drv1_up;
  logic ear_up;
  logic drv1_pd;
  logic ear_pd;
  modport guard (input diff, input drv1_up, input ear_up, output drv1_pd, output ear_pd);
  modport ctrl  (output diff, output drv1_up, output ear_up, input drv1_pd, input ear_pd);
endinterface

// ### design/pin_sync.sv
// two-stage synchroniser for a group of asynchronous pin inputs
`timescale 1ns/1ps
module pin_sync #(
  parameter int           W         = 3,
  parameter logic [W-1:0] RESET_VAL = '0
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  // a net collects the bits, so each bit's flops stay owned by one process
  wire [W-1:0] q_bits;

  // first stage feeds only the second stage
  generate
    for (genvar i = 0; i < W; i++) begin : g_bit
      logic meta_r;
      logic q_r;
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          meta_r <= RESET_VAL[i];
          q_r    <= RESET_VAL[i];
        end else if (ce) begin
          meta_r <= d[i];
          q_r    <= meta_r;
        end
      end
      assign q_bits[i] = q_r;
    end
  endgenerate

  assign q = q_bits;
endmodule

// ### design/diff_guard.sv
// forces speaker driver one and earpiece negative driver down in a bad differential setup
`timescale 1ns/1ps
module diff_guard (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  pd_if.guard      pd
);
  logic force_r;
  logic force_nxt;

  always_comb begin
    force_nxt = pd.diff && !(pd.drv1_up && pd.ear_up); // [RULE2]
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      force_r <= 1'b0;
    end else if (ce) begin
      force_r <= force_nxt;
    end
  end

  // both drivers always go down together
  assign pd.drv1_pd = force_r;
  assign pd.ear_pd  = force_r;
endmodule

// ### tb/speaker_driver_routing_control_tb.sv
// self-checking bench for the speaker driver routing register and its output controls
`timescale 1ns/1ps
module speaker_driver_routing_control_tb
  import spk_route_pkg::*;
;
  localparam int HALF = 6;

  logic             clk;
  logic             rst_n;
  logic             sclk;
  logic             cs_n;
  logic             mosi;
  logic             drv1_powered;
  logic             earpiece_powered;
  logic             ce;
  logic             miso;
  logic             miso_oe;
  logic             diff_output_select;
  logic [DAC_W-1:0] dac_route_drv1;
  logic             sidetone_route_drv1;
  logic             buzzer_route_drv1;
  logic             keyclick_route_drv1;
  logic             cellin_route_drv1;
  logic [DAC_W-1:0] dac_route_drv2;
  logic             sidetone_route_drv2;
  logic             buzzer_route_drv2;
  logic             keyclick_route_drv2;
  logic             cellin_route_drv2;
  logic             drv1_mute;
  logic             drv2_mute;
  logic             hp_short_prot_disable;
  logic             drv1_force_pd;
  logic             earpiece_force_pd;
  int               failures;
  int               check_count;
  logic [15:0]      cur;

  speaker_driver_routing_control dut (
    .clk                   (clk),
    .rst_n                 (rst_n),
    .ce                    (ce),
    .sclk                  (sclk),
    .cs_n                  (cs_n),
    .mosi                  (mosi),
    .drv1_powered          (drv1_powered),
    .earpiece_powered      (earpiece_powered),
    .miso                  (miso),
    .miso_oe               (miso_oe),
    .diff_output_select    (diff_output_select),
    .dac_route_drv1        (dac_route_drv1),
    .sidetone_route_drv1   (sidetone_route_drv1),
    .buzzer_route_drv1     (buzzer_route_drv1),
    .keyclick_route_drv1   (keyclick_route_drv1),
    .cellin_route_drv1     (cellin_route_drv1),
    .dac_route_drv2        (dac_route_drv2),
    .sidetone_route_drv2   (sidetone_route_drv2),
    .buzzer_route_drv2     (buzzer_route_drv2),
    .keyclick_route_drv2   (keyclick_route_drv2),
    .cellin_route_drv2     (cellin_route_drv2),
    .drv1_mute             (drv1_mute),
    .drv2_mute             (drv2_mute),
    .hp_short_prot_disable (hp_short_prot_disable),
    .drv1_force_pd         (drv1_force_pd),
    .earpiece_force_pd     (earpiece_force_pd)
  );

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // a hung serial sequence is cut short here
  initial begin
    repeat (90000) @(posedge clk);
    failures++;
    end_sim();
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // outputs packed in register bit order so one compare covers every field
  function automatic logic [15:0] outs();
    return {diff_output_select, dac_route_drv1, sidetone_route_drv1, buzzer_route_drv1,
            keyclick_route_drv1, cellin_route_drv1, dac_route_drv2, sidetone_route_drv2,
            buzzer_route_drv2, keyclick_route_drv2, cellin_route_drv2, drv1_mute,
            drv2_mute, hp_short_prot_disable};
  endfunction

  // differential mode turns driver two routes off and holds it muted
  function automatic logic [15:0] exp_out(input logic [15:0] v);
    return v[15] ? ((v & ~16'h01f8) | 16'h0002) : v;
  endfunction

  // half phases of 6 clk keep every sclk level well past the pin synchroniser
  task automatic frame(input logic [15:0] cmd, input logic [15:0] wdat, input int nbits,
                       output logic [15:0] rdat);
    logic [31:0] sh;
    sh = {cmd, wdat};
    rdat = 'x;
    cs_n = 1'b0;
    tick(4);
    for (int i = 0; i < nbits; i++) begin
      mosi = sh[31-i];
      tick(HALF);
      if (i >= 16) rdat[31-i] = miso;
      if (i == 16 && cmd[15]) chk("read enable", 16'h0001, {15'h0000, miso_oe});
      sclk = 1'b1;
      tick(HALF);
      sclk = 1'b0;
    end
    tick(HALF);
    cs_n = 1'b1;
    tick(8);
  endtask

  task automatic wr(input logic [15:0] cmd, input logic [15:0] v);
    logic [15:0] d;
    frame(cmd, v, 32, d);
  endtask

  task automatic rd(input logic [15:0] cmd, output logic [15:0] v);
    frame(cmd, 16'h0000, 32, v);
  endtask

  task automatic test_reset();
    logic [15:0] r;
    chk("reset outputs", 16'h0006, outs());
    chk("reset force", 16'h0000, {14'h0000, drv1_force_pd, earpiece_force_pd});
    rd(16'h9400, r);
    chk("reset read", 16'h0006, r);
    $display("done reset values");
  endtask

  task automatic test_fields();
    logic [15:0] v;
    logic [15:0] r;
    for (int k = 0; k < 4; k++) begin
      v = (16'(k) << 13) | (16'(3 - k) << 7) | (16'(k) << 1);
      v = v | ((k % 2 == 0) ? 16'h1428 : 16'h0a51);
      wr(16'h1400, v);
      tick(4);
      chk("field outputs", v, outs());
      chk("field mutes", v & 16'h0007, outs() & 16'h0007);
      chk("field drv2", v & 16'h0070, outs() & 16'h0070);
      rd(16'h9400, r);
      chk("field read", v & 16'hfffe, r);
      cur = v;
    end
    $display("done field routing");
  endtask

  task automatic test_unmapped();
    logic [15:0] r;
    wr(16'h0c00, 16'h8001);
    wr(16'h1420, 16'hffff);
    tick(4);
    chk("unmapped write", exp_out(cur), outs());
    rd(16'h8c00, r);
    chk("unmapped read page", 16'h0000, r);
    rd(16'h9420, r);
    chk("unmapped read addr", 16'h0000, r);
    $display("done unmapped access");
  endtask

  // with the clock enable low even a complete valid write frame must leave no trace
  task automatic test_freeze();
    ce = 1'b0;
    wr(16'h1400, 16'h8001);
    chk("frozen outputs", exp_out(cur), outs());
    chk("frozen force", 16'h0000, {14'h0000, drv1_force_pd, earpiece_force_pd});
    ce = 1'b1;
    tick(4);
    chk("thawed outputs", exp_out(cur), outs());
    $display("done clock enable hold");
  endtask

  task automatic test_abort();
    logic [15:0] r;
    frame(16'h1400, 16'hffff, 20, r);
    tick(4);
    chk("aborted write", exp_out(cur), outs());
    $display("done aborted frame");
  endtask

  task automatic test_diff();
    logic [15:0] r;
    logic        f;
    wr(16'h1400, 16'hffff);
    tick(4);
    chk("diff outputs", exp_out(16'hffff), outs());
    rd(16'h9400, r);
    chk("diff read", 16'hfffe, r);
    for (int p = 0; p < 4; p++) begin
      drv1_powered = p[0];
      earpiece_powered = p[1];
      tick(4);
      f = (p != 3);
      chk("diff force", {14'h0000, f, f}, {14'h0000, drv1_force_pd, earpiece_force_pd});
    end
    drv1_powered = 1'b0;
    earpiece_powered = 1'b0;
    wr(16'h1400, 16'h0000);
    tick(4);
    chk("single force", 16'h0000, {14'h0000, drv1_force_pd, earpiece_force_pd});
    chk("single outputs", 16'h0000, outs());
    $display("done differential mode");
  endtask

  initial begin
    failures = 0;
    check_count = 0;
    cur = 16'h0006;
    rst_n = 1'b0;
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
    drv1_powered = 1'b0;
    earpiece_powered = 1'b0;
    ce = 1'b1;
    tick(10);
    rst_n = 1'b1;
    tick(4);
    test_reset();
    test_fields();
    test_unmapped();
    test_freeze();
    test_abort();
    test_diff();
    end_sim();
  end
endmodule
